// ==== rtl/pvsi_pkg.sv ====
package pvsi_pkg;

  // ----------------------------------------------------------------
  // Clock and bit rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 10000000;
  localparam int unsigned R64K_HZ  = 64000;
  localparam int unsigned R128K_HZ = 128000;
  localparam int unsigned R256K_HZ = 256000;
  localparam int unsigned R512K_HZ = 512000;
  localparam int unsigned R1M_HZ   = 1024000;
  localparam int unsigned RMUX_HZ  = 2304000;
  // Half bit periods in mclk cycles, rounded up so no rate is exceeded
  localparam logic [7:0] HALF_64K  = 8'((CLK_HZ + 2*R64K_HZ - 1) / (2*R64K_HZ));
  localparam logic [7:0] HALF_128K = 8'((CLK_HZ + 2*R128K_HZ - 1) / (2*R128K_HZ));
  localparam logic [7:0] HALF_256K = 8'((CLK_HZ + 2*R256K_HZ - 1) / (2*R256K_HZ));
  localparam logic [7:0] HALF_512K = 8'((CLK_HZ + 2*R512K_HZ - 1) / (2*R512K_HZ));
  localparam logic [7:0] HALF_1M   = 8'((CLK_HZ + 2*R1M_HZ - 1) / (2*R1M_HZ));
  localparam logic [7:0] HALF_MUX  = 8'((CLK_HZ + 2*RMUX_HZ - 1) / (2*RMUX_HZ));
  localparam logic [7:0] HALF_BURST = 8'h01;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FMT  = 8'h04;
  localparam logic [7:0] A_SLOT = 8'h08;
  localparam logic [7:0] A_TXD0 = 8'h0c;
  localparam logic [7:0] A_RXD0 = 8'h18;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam int CTRL_EN = 0, CTRL_MST = 1, CTRL_LONG = 2, CTRL_MODE = 3;
  localparam int CTRL_RATE = 5, CTRL_BURST = 8, CTRL_V16 = 9;
  localparam int CTRL_MIX = 10, CTRL_SLOTS = 12;
  localparam int FMT_SHIFT = 0, FMT_LSBF = 2, FMT_FILL = 3, FMT_FVAL = 5;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0]  FMT_RST  = 8'h03;
  localparam logic [23:0] SLOT_RST = 24'h000000;

  // ----------------------------------------------------------------
  // Modes, fills, states and counts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NARROW = 2'h0, MODE_WIDEBAND_VOICE = 2'h1,
    MODE_SUBBAND_CODED = 2'h2, MODE_MUX = 2'h3
  } pvsi_mode_t;
  typedef enum logic [1:0] {
    FILL_ZERO = 2'h0, FILL_ONE = 2'h1, FILL_SIGN = 2'h2, FILL_VAL = 2'h3
  } pvsi_fill_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_HUNT = 3'h2, ST_RUN = 3'h4
  } pvsi_state_t;
  localparam int         NCH       = 3;
  localparam logic [2:0] REP_8K    = 3'h6;
  localparam logic [2:0] REP_16K   = 3'h3;
  localparam logic [7:0] LONG_BITS = 8'h03;
  localparam logic [3:0] MUX_SM1   = 4'h2;

endpackage

// ==== rtl/pvsi_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvsi_chan (
  input  wire logic        mclk_i,   // System clock
  input  wire logic        nrst_i,   // Async reset, active low
  input  wire logic        rise_i,   // Bit clock rising edge
  input  wire logic        fall_i,   // Bit clock falling edge
  input  wire logic        hit_i,    // Current bit is in our slot
  input  wire logic [3:0]  idx_i,    // Bit index within slot
  input  wire logic        narrow_i, // 13-bit narrowband packing
  input  wire logic        lsbf_i,   // Shift LSB first
  input  wire logic [1:0]  shift_i,  // LSB position of 13-bit sample
  input  wire logic [1:0]  fill_i,   // Pad bit fill kind
  input  wire logic [2:0]  fval_i,   // Programmed pad value
  input  wire logic [15:0] txw_i,    // Sample to send
  input  wire logic        din_i,    // Synchronised serial input
  output logic             dout_o,   // Serial output bit
  output logic             oe_o,     // Serial output enable
  output logic [15:0]      rxw_o,    // Received sample
  output logic             rxstb_o   // Received sample strobe
);
  logic [15:0] s16, msk, pad, fmt, txw_r, rxs_r, rxa, rsh;
  logic [3:0]  pos;

  // ----------------------------------------------------------------
  // Word packing
  // ----------------------------------------------------------------
  // Pad bits take the fill; a split pad takes both ends of the value
  always_comb begin
    s16 = {3'h0, txw_i[12:0]} << shift_i;
    msk = 16'h1fff << shift_i;
    unique case (pvsi_pkg::pvsi_fill_t'(fill_i))
      pvsi_pkg::FILL_ZERO: pad = 16'h0000;
      pvsi_pkg::FILL_ONE:  pad = 16'hffff;
      pvsi_pkg::FILL_SIGN: pad = {16{txw_i[12]}};
      pvsi_pkg::FILL_VAL:  pad = {fval_i, 10'h000, fval_i};
    endcase
    fmt = narrow_i ? ((s16 & msk) | (pad & ~msk)) : txw_i;
    pos = lsbf_i ? idx_i : 4'hf - idx_i;
    rxa = rxs_r;
    rxa[pos] = din_i;
    rsh = rxa >> shift_i;
  end

  // Launch on rising edges; release after the falling edge of bit 15
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txw_r  <= 16'h0000;
      dout_o <= 1'b0;
      oe_o   <= 1'b0;
    end else if (rise_i) begin
      oe_o <= hit_i;
      if (hit_i && idx_i == 4'h0) begin
        txw_r  <= fmt;
        dout_o <= fmt[pos];
      end else begin
        dout_o <= hit_i & txw_r[pos];
      end
    end else if (fall_i && oe_o && idx_i == 4'hf) begin
      oe_o <= 1'b0;
    end else if (!hit_i) begin
      // A stop between edges must not leave the line driven
      oe_o <= 1'b0;
    end
  end

  // Sample on falling edges; pad bits are dropped on receive
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxs_r   <= 16'h0000;
      rxw_o   <= 16'h0000;
      rxstb_o <= 1'b0;
    end else begin
      rxstb_o <= 1'b0;
      if (fall_i && hit_i) begin
        rxs_r <= rxa;
        if (idx_i == 4'hf) begin
          rxw_o   <= narrow_i ? {{3{rsh[12]}}, rsh[12:0]} : rxa;
          rxstb_o <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/pvsi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvsi_top (
  input  wire logic        mclk_i,     // System clock, 10 MHz
  input  wire logic        nrst_i,     // Async reset, active low
  input  wire logic        hsel_i,     // AHB select
  input  wire logic [31:0] haddr_i,    // AHB address
  input  wire logic [1:0]  htrans_i,   // AHB transfer type
  input  wire logic        hwrite_i,   // AHB write
  input  wire logic [2:0]  hsize_i,    // AHB size
  input  wire logic [31:0] hwdata_i,   // AHB write data
  input  wire logic        hready_i,   // AHB bus ready
  output logic             hreadyout_o,// AHB slave ready
  output logic             hresp_o,    // AHB response, always OKAY
  output logic [31:0]      hrdata_o,   // AHB read data
  input  wire logic        bclk_i,     // Bit clock pin in
  output logic             bclk_o,     // Bit clock pin out
  output logic             bclk_oe_o,  // Bit clock drive enable
  input  wire logic        sync_i,     // Frame sync pin in
  output logic             sync_o,     // Frame sync pin out
  output logic             sync_oe_o,  // Frame sync drive enable
  input  wire logic        din_i,      // Serial data in
  output logic             dout_o,     // Serial data out
  output logic             dout_oe_o   // Serial data drive enable
);
  logic [15:0] ctrl_r;
  logic [7:0]  fmt_r, wa_r, half, half_m1, div_r, cnt_r, cnt_nxt, cur, last;
  logic [23:0] slot_r;
  logic [15:0] txd_r [pvsi_pkg::NCH];
  logic [15:0] rxd_r [pvsi_pkg::NCH];
  logic [15:0] rxw [pvsi_pkg::NCH];
  logic [2:0]  rxnew_r, rxstb, hit, doutv, oev, rep_r, rep_n, rep_nxt;
  logic [2:0]  bs, ss, ds;
  logic        wr_r, ap, en, mst, lng, v16, mix, narrow, run, bclk_r;
  logic        tick, rise, fall, det, sprev_r, pend_r, locked_r, fstart;
  logic [3:0]  slots_m1;
  logic [15:0] vsh_r, w0;
  logic [31:0] rdv;
  pvsi_pkg::pvsi_mode_t  mode;
  pvsi_pkg::pvsi_state_t state_r;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign en   = ctrl_r[pvsi_pkg::CTRL_EN];
  assign mst  = ctrl_r[pvsi_pkg::CTRL_MST];
  assign lng  = ctrl_r[pvsi_pkg::CTRL_LONG];
  assign mode = pvsi_pkg::pvsi_mode_t'(ctrl_r[pvsi_pkg::CTRL_MODE +: 2]);
  assign v16  = ctrl_r[pvsi_pkg::CTRL_V16];
  assign mix  = ctrl_r[pvsi_pkg::CTRL_MIX] & mst;
  // Wideband and subband words carry all 16 bits
  assign narrow = (mode == pvsi_pkg::MODE_NARROW);
  assign slots_m1 = (mode == pvsi_pkg::MODE_MUX) ? pvsi_pkg::MUX_SM1
                  : ctrl_r[pvsi_pkg::CTRL_SLOTS +: 4];
  assign last = {slots_m1, 4'hf};
  assign run  = (state_r == pvsi_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit 0 feeds only bit 1; bits 1 and 2 are the usable taps
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bs <= 3'h0;
      ss <= 3'h0;
      ds <= 3'h0;
    end else begin
      bs <= {bs[1:0], bclk_i};
      ss <= {ss[1:0], sync_i};
      ds <= {ds[1:0], din_i};
    end
  end

  // ----------------------------------------------------------------
  // Bit clock divider and edges
  // ----------------------------------------------------------------
  // At 10 MHz burst tops out at 5 MHz, well under the pin limit
  always_comb begin
    unique case (ctrl_r[pvsi_pkg::CTRL_RATE +: 3])
      3'h0: half = pvsi_pkg::HALF_64K;
      3'h1: half = pvsi_pkg::HALF_128K;
      3'h2: half = pvsi_pkg::HALF_256K;
      3'h3: half = pvsi_pkg::HALF_512K;
      3'h4: half = pvsi_pkg::HALF_1M;
      3'h5: half = pvsi_pkg::HALF_MUX;
      default: half = pvsi_pkg::HALF_BURST;
    endcase
    if (ctrl_r[pvsi_pkg::CTRL_BURST]) begin
      half = pvsi_pkg::HALF_BURST;
    end
    half_m1 = half - 8'h01;
  end

  assign tick = en & mst & (div_r == half_m1);
  // Master edges are known one cycle ahead; slave edges come from taps
  assign rise = mst ? (tick & ~bclk_r) : (bs[1] & ~bs[2]);
  assign fall = mst ? (tick & bclk_r) : (~bs[1] & bs[2]);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r  <= 8'h00;
      bclk_r <= 1'b0;
    end else if (!(en && mst)) begin
      div_r  <= 8'h00;
      bclk_r <= 1'b0;
    end else if (tick) begin
      div_r  <= 8'h00;
      bclk_r <= ~bclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Frame state and bit counter
  // ----------------------------------------------------------------
  // Long sync is found by its leading edge, short sync by its level
  assign det = lng ? (ss[1] & ~sprev_r) : ss[1];
  assign cnt_nxt = (pend_r || cnt_r == last) ? 8'h00 : cnt_r + 8'h01;
  assign cur = rise ? cnt_nxt : cnt_r;
  assign fstart = rise & run & (cnt_nxt == 8'h00);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= pvsi_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        pvsi_pkg::ST_IDLE:
          if (en) begin
            state_r <= mst ? pvsi_pkg::ST_RUN : pvsi_pkg::ST_HUNT;
          end
        pvsi_pkg::ST_HUNT:
          if (!en) begin
            state_r <= pvsi_pkg::ST_IDLE;
          end else if (fall && det) begin
            state_r <= pvsi_pkg::ST_RUN;
          end
        pvsi_pkg::ST_RUN:
          if (!en) begin
            state_r <= pvsi_pkg::ST_IDLE;
          end
        default: state_r <= pvsi_pkg::ST_IDLE;
      endcase
    end
  end

  // Slave realigns on every sync so a slipped edge heals in one frame
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r    <= 8'h00;
      pend_r   <= 1'b0;
      sprev_r  <= 1'b0;
      locked_r <= 1'b0;
    end else if (state_r == pvsi_pkg::ST_IDLE) begin
      cnt_r    <= last;
      pend_r   <= 1'b0;
      locked_r <= 1'b0;
    end else if (rise) begin
      pend_r <= 1'b0;
      if (run || pend_r) begin
        cnt_r <= cnt_nxt;
      end
    end else if (fall && !mst) begin
      sprev_r <= ss[1];
      if (det) begin
        locked_r <= 1'b1;
        if (lng) begin
          cnt_r <= 8'h00;
        end else begin
          pend_r <= 1'b1;
        end
      end
    end
  end

  // Master sync: short is the bit before bit 0, long is bits 0 to 2
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_o <= 1'b0;
    end else if (!(en && mst)) begin
      sync_o <= 1'b0;
    end else if (rise) begin
      sync_o <= lng ? (cnt_nxt < pvsi_pkg::LONG_BITS)
                    : (cnt_nxt == last);
    end
  end

  // Pins are released when stopped so a shared I2S port can use them
  assign bclk_o    = bclk_r;
  assign bclk_oe_o = en & mst;
  assign sync_oe_o = en & mst;

  // ----------------------------------------------------------------
  // Multiplexed voice repetition
  // ----------------------------------------------------------------
  // Mixed streams fill the repeats themselves, so no repetition then
  assign rep_n = mix ? 3'h1 : (v16 ? pvsi_pkg::REP_16K : pvsi_pkg::REP_8K);
  assign rep_nxt = (rep_r >= rep_n - 3'h1) ? 3'h0 : rep_r + 3'h1;
  assign w0 = (mode != pvsi_pkg::MODE_MUX) ? txd_r[0]
            : ((rep_nxt == 3'h0) ? txd_r[0] : vsh_r);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rep_r <= 3'h7;
      vsh_r <= 16'h0000;
    end else if (!run) begin
      rep_r <= 3'h7;
    end else if (fstart) begin
      rep_r <= rep_nxt;
      if (rep_nxt == 3'h0) begin
        vsh_r <= txd_r[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot channels
  // ----------------------------------------------------------------
  // Multiplexed mode fixes voice, FM left, FM right in slots 0 to 2
  for (genvar i = 0; i < pvsi_pkg::NCH; i++) begin : g_ch
    logic [3:0] sl;
    logic       ce;
    assign sl = (mode == pvsi_pkg::MODE_MUX) ? 4'(i)
              : slot_r[8*i +: 4];
    assign ce = (mode == pvsi_pkg::MODE_MUX) | slot_r[8*i+7];
    assign hit[i] = run & ce & (cur[7:4] == sl);
    pvsi_chan u_ch (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .rise_i   (rise),
      .fall_i   (fall),
      .hit_i    (hit[i]),
      .idx_i    (cur[3:0]),
      .narrow_i (narrow),
      .lsbf_i   (fmt_r[pvsi_pkg::FMT_LSBF]),
      .shift_i  (fmt_r[pvsi_pkg::FMT_SHIFT +: 2]),
      .fill_i   (fmt_r[pvsi_pkg::FMT_FILL +: 2]),
      .fval_i   (fmt_r[pvsi_pkg::FMT_FVAL +: 3]),
      .txw_i    ((i == 0) ? w0 : txd_r[i]),
      .din_i    (ds[1]),
      .dout_o   (doutv[i]),
      .oe_o     (oev[i]),
      .rxw_o    (rxw[i]),
      .rxstb_o  (rxstb[i])
    );
  end

  // Only one slot owns the line, so OR-ing is safe
  assign dout_o    = |(doutv & oev);
  assign dout_oe_o = |oev;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states: read data are latched in the address phase
  assign ap = hsel_i & hready_i & htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_comb begin
    rdv = 32'h00000000;
    if (haddr_i[31:8] == 24'h000000) begin
      unique case (haddr_i[7:0])
        pvsi_pkg::A_CTRL: rdv = {16'h0000, ctrl_r};
        pvsi_pkg::A_FMT:  rdv = {24'h000000, fmt_r};
        pvsi_pkg::A_SLOT: rdv = {8'h00, slot_r};
        pvsi_pkg::A_TXD0: rdv = {16'h0000, txd_r[0]};
        8'h10:            rdv = {16'h0000, txd_r[1]};
        8'h14:            rdv = {16'h0000, txd_r[2]};
        pvsi_pkg::A_RXD0: rdv = {16'h0000, rxd_r[0]};
        8'h1c:            rdv = {16'h0000, rxd_r[1]};
        8'h20:            rdv = {16'h0000, rxd_r[2]};
        pvsi_pkg::A_STAT: rdv = {27'h0000000, rxnew_r, locked_r, run};
        default:          rdv = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_r     <= 1'b0;
      wa_r     <= 8'h00;
      hrdata_o <= 32'h00000000;
    end else begin
      wr_r <= ap & hwrite_i & (hsize_i == 3'h2)
            & (haddr_i[31:8] == 24'h000000);
      wa_r <= haddr_i[7:0];
      if (ap && !hwrite_i) begin
        hrdata_o <= rdv;
      end
    end
  end

  // Mode fields are frozen while running; only stopping gets through
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= pvsi_pkg::CTRL_RST;
      fmt_r  <= pvsi_pkg::FMT_RST;
      slot_r <= pvsi_pkg::SLOT_RST;
    end else if (wr_r) begin
      if (wa_r == pvsi_pkg::A_CTRL) begin
        if (en) begin
          ctrl_r[pvsi_pkg::CTRL_EN] <= hwdata_i[0];
        end else begin
          ctrl_r <= hwdata_i[15:0];
        end
      end
      if (wa_r == pvsi_pkg::A_FMT && !en) begin
        fmt_r <= hwdata_i[7:0];
      end
      if (wa_r == pvsi_pkg::A_SLOT && !en) begin
        slot_r <= hwdata_i[23:0];
      end
    end
  end

  // Received words; a new arrival beats a clearing read
  for (genvar i = 0; i < pvsi_pkg::NCH; i++) begin : g_rg
    logic [7:0] ta, ra;
    assign ta = pvsi_pkg::A_TXD0 + 8'(4*i);
    assign ra = pvsi_pkg::A_RXD0 + 8'(4*i);
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        txd_r[i]   <= 16'h0000;
        rxd_r[i]   <= 16'h0000;
        rxnew_r[i] <= 1'b0;
      end else begin
        if (wr_r && wa_r == ta) begin
          txd_r[i] <= hwdata_i[15:0];
        end
        if (rxstb[i]) begin
          rxd_r[i]   <= rxw[i];
          rxnew_r[i] <= 1'b1;
        end else if (ap && !hwrite_i && haddr_i == {24'h000000, ra}) begin
          rxnew_r[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  chk_unowned_release: assert property (
    rise && hit == 3'h0 |=> !dout_oe_o)
    else $error("data driven in an unowned slot");
  chk_last_bit_off: assert property (
    fall && cnt_r[3:0] == 4'hf && dout_oe_o && !rise |=> !dout_oe_o)
    else $error("driver not released after last bit");
  chk_short_width: assert property (
    en && mst && !lng && rise && sync_o |=> !sync_o)
    else $error("short sync wider than one bit");
  chk_long_width: assert property (
    en && mst && lng && rise && cnt_nxt == 8'h00 ##1 (!rise)[*1]
    |-> sync_o ##0 (cnt_r == 8'h00))
    else $error("long sync not high at bit 0");
  chk_long_end: assert property (
    en && mst && lng && rise && cnt_nxt == 8'h03 |=> !sync_o)
    else $error("long sync longer than three bits");
  chk_slave_bit0: assert property (
    pend_r && rise && en |=> cnt_r == 8'h00)
    else $error("slot zero not started after short sync");
  chk_cfg_frozen: assert property (
    en && $past(en) |-> $stable(fmt_r) && $stable(slot_r)
    && $stable(ctrl_r[15:1]))
    else $error("configuration changed while running");
  chk_voice_repeat: assert property (
    fstart && rep_nxt != 3'h0 |=> $stable(vsh_r))
    else $error("voice sample replaced before its repeats");
  chk_slave_pins: assert property (
    !mst |-> !bclk_oe_o && !sync_oe_o)
    else $error("slave drives clock or sync");

endmodule
`default_nettype wire

// ==== sim/pvsi_codec.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvsi_codec (
  input  wire logic        run_i,  // Keep sending frames
  input  wire logic [15:0] word_i, // Word for slot zero
  output logic             bclk_o, // Bit clock, still outside frames
  output logic             sync_o, // Short frame sync
  output logic             din_o   // Serial data to the block
);
  int i;
  // ----------------------------------------------------
  // Frame maker
  // ----------------------------------------------------
  // 800 ns bits; the line flips when released so no stale bit survives
  initial begin
    bclk_o = 1'b0;
    sync_o = 1'b0;
    din_o  = 1'b0;
    forever begin
      wait (run_i);
      #13;
      for (i = -1; i < 16; i++) begin
        sync_o = (i < 0);
        din_o  = (i < 0) ? ~din_o : word_i[15-i];
        bclk_o = 1'b1;
        #400 bclk_o = 1'b0;
        #400;
      end
      sync_o = 1'b0;
      din_o  = ~din_o;
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, got;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2, v, pad;
  logic        hreadyout_o, hresp_o, bclk_o, bclk_oe_o, sync_o, sync_oe_o;
  logic        dout_o, dout_oe_o, c_bclk, c_sync, c_din, pb, run = 1'b0;
  logic [15:0] cword = 16'h0, sh = 16'h0;
  logic [12:0] s;
  logic [31:0] rq[$];
  logic [15:0] sq[$];
  int          fails = 0, total_checks = 0, seed = 95132, n = 0, f, k;
  event        rd_ev;
  wire logic   bclk_w = bclk_oe_o ? bclk_o : c_bclk;
  wire logic   sync_w = sync_oe_o ? sync_o : c_sync;

  pvsi_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o),
    .sync_i(sync_w), .sync_o(sync_o), .sync_oe_o(sync_oe_o),
    .din_i(c_din), .dout_o(dout_o), .dout_oe_o(dout_oe_o));
  pvsi_codec codec (.run_i(run), .word_i(cword), .bclk_o(c_bclk),
    .sync_o(c_sync), .din_o(c_din));

  // ----------------------------------------------------
  // Clock, checks and bus cycles
  // ----------------------------------------------------
  initial forever #50 mclk_i = ~mclk_i;
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    got = hrdata_o;
    if (!w) ->rd_ev;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    rq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic print_verdict;
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Read data and serial words each meet the oldest note
  always @(rd_ev) begin
    cmp("hrdata", rq.pop_front(), got);
    cmp("hresp", 32'h0, 32'(hresp_o));
  end
  // Bits are taken one cycle after the bit clock rise, once settled
  always @(posedge mclk_i) begin
    if (bclk_o === 1'b1 && pb === 1'b0 && dout_oe_o === 1'b1) begin
      sh = {sh[14:0], dout_o};
      n++;
      cmp("sync", 32'(n == 16 && f < 4), 32'(sync_o));
      if (n == 16 && sq.size() > 0) begin
        cmp("dout", sq.pop_front(), sh);
      end
      if (n == 16) begin
        cmp("drive", 32'h1, 32'(bclk_oe_o & sync_oe_o));
        n = 0;
      end
    end
    pb = bclk_o;
  end
  // A hang is cut short well past the expected run length
  initial begin
    #2000000;
    fails++;
    print_verdict;
  end

  // ----------------------------------------------------
  // Main sequence
  // ----------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h3);
    rd(8'h80, 32'h0);
    s = 13'($random(seed));
    ahb(1'b1, 8'h0c, {19'h0, s});
    ahb(1'b1, 8'h08, 32'h81);
    // The last pass sends a whole wideband word under a long sync
    for (f = 0; f < 5; f++) begin
      v = 3'($random(seed));
      pad = (f == 0) ? 3'h0 : (f == 1) ? 3'h7 : (f == 2) ? {3{s[12]}} : v;
      ahb(1'b1, 8'h04, {24'h0, v, 2'(f), 3'h3});
      sq.push_back((f == 4) ? {3'h0, s} : {s, pad});
      sq.push_back((f == 4) ? {3'h0, s} : {s, pad});
      ahb(1'b1, 8'h00, (f == 4) ? 32'h108f : 32'h1083);
      for (k = 0; k < 3000 && sq.size() > 0; k++) @(posedge mclk_i);
      cmp("words left", 32'h0, sq.size());
      ahb(1'b1, 8'h00, 32'h0);
      n = 0;
    end
    cword = 16'($random(seed));
    ahb(1'b1, 8'h08, 32'h80);
    ahb(1'b1, 8'h00, 32'h1);
    run <= 1'b1;
    repeat (300) @(posedge mclk_i);
    rd(8'h24, 32'h7);
    ahb(1'b1, 8'h04, 32'h0);
    rd(8'h04, {24'h0, v, 5'h03});
    run <= 1'b0;
    repeat (300) @(posedge mclk_i);
    rd(8'h18, {16'h0, {3{cword[15]}}, cword[15:3]});
    print_verdict;
  end
endmodule
`default_nettype wire
